// ==== shared/spc_map.vh ====
// Opcodes, register addresses and bit positions for the protection command host controller.
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
`define SPC_OP_WRITE_ENABLE_CMD      8'h06
`define SPC_OP_RDSR      8'h05
`define SPC_OP_RD_PPB    8'hFC
`define SPC_OP_RD_PPB4   8'hE2
`define SPC_OP_PG_PPB    8'hFD
`define SPC_OP_PG_PPB4   8'hE3
`define SPC_OP_ER_PPB    8'hE4
`define SPC_OP_RD_CFG    8'h2B
`define SPC_OP_PG_CFG    8'h2F
`define SPC_OP_RD_LOCK   8'hA7
`define SPC_OP_CLR_LOCK  8'hA6
`define SPC_OP_FREEZE    8'h91
`define SPC_OP_RD_KEY    8'hE7
`define SPC_OP_PG_KEY    8'hE8
`define SPC_REG_CTRL     4'h0
`define SPC_REG_ADDR     4'h1
`define SPC_REG_WLO      4'h2
`define SPC_REG_WHI      4'h3
`define SPC_REG_STAT     4'h4
`define SPC_REG_RLO      4'h5
`define SPC_REG_RHI      4'h6
`define SPC_CTRL_GO      8
`define SPC_CTRL_WIDE    9
`define SPC_STAT_BUSY    0
`define SPC_STAT_ERR     1
`define SPC_WIP_BIT      0
`define SPC_SCK_HALF     4'h9
`define SPC_POLL_MAX     16'hFFFF
`endif

// ==== rtl/spc_div.v ====
// Serial clock half-period divider producing one-cycle enable pulses.
`timescale 1ns/1ns
`default_nettype none
module spc_div #(
    parameter HALF = 10
) (
    input  wire clk_sys,
    input  wire arst_n,
    input  wire run,
    output reg  tick_ff
);
    reg [7:0] cnt_ff;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (cnt_ff == HALF[7:0] - 8'h01) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/spc_host.v ====
// Host controller issuing protection commands to a serial flash.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "spc_map.vh"
module spc_host #(
    parameter SCK_HALF = 10,
    parameter POLL_MAX = 65535
) (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata_ff,
    output reg         cs_n_ff,
    output reg         sck_ff,
    output reg         mosi_ff,
    input  wire        miso
);
    localparam ST_IDLE = 3'd0;
    localparam ST_WRITE_ENABLE_CMD = 3'd1;
    localparam ST_GAP  = 3'd2;
    localparam ST_MAIN = 3'd3;
    localparam ST_POLL = 3'd4;
    localparam ST_DONE = 3'd5;

    reg  [2:0]  state_ff;
    reg  [7:0]  op_ff;
    reg         wide_ff;
    reg  [31:0] addr_ff;
    reg  [31:0] wlo_ff;
    reg  [31:0] whi_ff;
    reg  [63:0] rdata_ff;
    reg  [63:0] rsh_ff;
    reg  [63:0] wdat_ff;
    reg  [7:0]  abytes_ff;
    reg  [6:0]  rbits_ff;
    reg  [6:0]  wbits_ff;
    reg         busy_ff;
    reg         err_ff;
    reg  [103:0] sh_ff;
    reg  [7:0]  nbits_ff;
    reg  [7:0]  cnt_ff;
    reg  [6:0]  rcnt_ff;
    reg         phase_ff;
    reg  [15:0] polls_ff;
    reg         miso_m_ff;
    reg         miso_s_ff;
    wire        tick;
    wire        run;
    reg  [6:0]  nxt_rbits;
    reg  [6:0]  nxt_wbits;
    reg  [1:0]  nxt_amode;
    reg         nxt_wr;

    // Miso from the flash is outside our domain; two stages first.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            miso_m_ff <= 1'b0;
            miso_s_ff <= 1'b0;
        end else begin
            miso_m_ff <= miso;
            miso_s_ff <= miso_m_ff;
        end
    end

    assign run = (state_ff == ST_WRITE_ENABLE_CMD) || (state_ff == ST_MAIN) ||
                 (state_ff == ST_POLL);

    spc_div #(.HALF(SCK_HALF)) u_div (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .run     (run && !cs_n_ff),
        .tick_ff (tick)
    );

    // Command shape: address kind (0 none, 1 by flag, 2 four bytes).
    always @* begin
        nxt_amode = 2'd0;
        nxt_rbits = 7'd0;
        nxt_wbits = 7'd0;
        nxt_wr    = 1'b0;
        case (op_ff)
            `SPC_OP_RD_PPB:   begin nxt_amode = 2'd1; nxt_rbits = 7'd8; end
            `SPC_OP_RD_PPB4:  begin nxt_amode = 2'd2; nxt_rbits = 7'd8; end
            `SPC_OP_PG_PPB:   begin nxt_amode = 2'd1; nxt_wr = 1'b1; end
            `SPC_OP_PG_PPB4:  begin nxt_amode = 2'd2; nxt_wr = 1'b1; end
            `SPC_OP_ER_PPB:   nxt_wr = 1'b1;
            `SPC_OP_RD_CFG:   nxt_rbits = 7'd16;
            `SPC_OP_PG_CFG:   begin nxt_wbits = 7'd16; nxt_wr = 1'b1; end
            `SPC_OP_RD_LOCK:  nxt_rbits = 7'd8;
            `SPC_OP_CLR_LOCK: nxt_wr = 1'b1;
            `SPC_OP_FREEZE:   nxt_wr = 1'b1;
            `SPC_OP_RD_KEY:   nxt_rbits = 7'd64;
            `SPC_OP_PG_KEY:   begin nxt_wbits = 7'd64; nxt_wr = 1'b1; end
            default:          nxt_amode = 2'd0;
        endcase
    end

    // Register port: read data one cycle after the strobe.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SPC_REG_CTRL: reg_rdata_ff <= {22'h000000, wide_ff, 1'b0, op_ff};
                `SPC_REG_ADDR: reg_rdata_ff <= addr_ff;
                `SPC_REG_WLO:  reg_rdata_ff <= wlo_ff;
                `SPC_REG_WHI:  reg_rdata_ff <= whi_ff;
                `SPC_REG_STAT: reg_rdata_ff <= {30'h00000000, err_ff, busy_ff};
                `SPC_REG_RLO:  reg_rdata_ff <= rdata_ff[31:0];
                `SPC_REG_RHI:  reg_rdata_ff <= rdata_ff[63:32];
                default:       reg_rdata_ff <= 32'h00000000;
            endcase
        end
    end

    // Byte-order swap so the low byte leaves first, MSB of each first.
    function [63:0] spc_lsb_first;
        input [63:0] v;
        integer i;
        begin
            spc_lsb_first = 64'h0;
            for (i = 0; i < 8; i = i + 1)
                spc_lsb_first[63-8*i -: 8] = v[8*i +: 8];
        end
    endfunction

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff  <= ST_IDLE;
            op_ff     <= 8'h00;
            wide_ff   <= 1'b0;
            addr_ff   <= 32'h00000000;
            wlo_ff    <= 32'h00000000;
            whi_ff    <= 32'h00000000;
            rdata_ff  <= 64'h0;
            rsh_ff    <= 64'h0;
            wdat_ff   <= 64'h0;
            abytes_ff <= 8'h00;
            rbits_ff  <= 7'd0;
            wbits_ff  <= 7'd0;
            busy_ff   <= 1'b0;
            err_ff    <= 1'b0;
            sh_ff     <= 104'h0;
            nbits_ff  <= 8'h00;
            cnt_ff    <= 8'h00;
            rcnt_ff   <= 7'd0;
            phase_ff  <= 1'b0;
            polls_ff  <= 16'h0000;
            cs_n_ff   <= 1'b1;
            sck_ff    <= 1'b0;
            mosi_ff   <= 1'b0;
        end else begin
            if (reg_wr && !busy_ff) begin
                case (reg_addr)
                    `SPC_REG_ADDR: addr_ff <= reg_wdata;
                    `SPC_REG_WLO:  wlo_ff <= reg_wdata;
                    `SPC_REG_WHI:  whi_ff <= reg_wdata;
                    `SPC_REG_CTRL: begin
                        op_ff   <= reg_wdata[7:0];
                        wide_ff <= reg_wdata[`SPC_CTRL_WIDE];
                        if (reg_wdata[`SPC_CTRL_GO]) begin
                            busy_ff <= 1'b1;
                            err_ff  <= 1'b0;
                            state_ff <= ST_GAP;
                        end
                    end
                    default: busy_ff <= busy_ff;
                endcase
            end
            case (state_ff)
                ST_IDLE: cs_n_ff <= 1'b1;
                ST_GAP: begin
                    // Every command waits for the flash to be idle.
                    sh_ff    <= {8'h05, 96'h0};
                    nbits_ff <= 8'd8;
                    rbits_ff <= 7'd8;
                    wbits_ff <= 7'd0;
                    abytes_ff <= 8'h00;
                    cnt_ff   <= 8'h00;
                    rcnt_ff  <= 7'd0;
                    phase_ff <= 1'b0;
                    polls_ff <= 16'h0000;
                    cs_n_ff  <= 1'b0;
                    mosi_ff  <= 1'b0;
                    state_ff <= ST_POLL;
                end
                ST_WRITE_ENABLE_CMD, ST_MAIN, ST_POLL: if (tick) begin
                    if (!phase_ff) begin
                        // Rising edge: the flash samples our bit here.
                        sck_ff   <= 1'b1;
                        phase_ff <= 1'b1;
                    end else begin
                        sck_ff   <= 1'b0;
                        phase_ff <= 1'b0;
                        if (cnt_ff < nbits_ff) begin
                            mosi_ff <= sh_ff[102];
                            sh_ff   <= {sh_ff[102:0], 1'b0};
                            cnt_ff  <= cnt_ff + 8'h01;
                        end else begin
                            // Sampled on the falling edge; data settled.
                            rsh_ff  <= {rsh_ff[62:0], miso_s_ff};
                            rcnt_ff <= rcnt_ff + 7'd1;
                        end
                        // A frame with no read phase ends on its last out bit.
                        if ((cnt_ff < nbits_ff) ?
                            (cnt_ff + 8'h01 == nbits_ff &&
                             rbits_ff == 7'd0) :
                            (rcnt_ff + 7'd1 >= rbits_ff)) begin
                            // Stop exactly on the boundary, no extra bits.
                            cs_n_ff <= 1'b1;
                            sck_ff  <= 1'b0;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
            // Between frames: pick the next one and put its first bit out.
            if ((state_ff == ST_POLL || state_ff == ST_WRITE_ENABLE_CMD ||
                 state_ff == ST_MAIN) && cs_n_ff && !(state_ff == ST_GAP)) begin
                cnt_ff  <= 8'h00;
                rcnt_ff <= 7'd0;
                if (state_ff == ST_POLL) begin
                    if (rsh_ff[`SPC_WIP_BIT] == 1'b0) begin
                        if (rbits_ff == 7'd8 && nbits_ff == 8'd8 &&
                            op_ff != 8'h00 && wbits_ff == 7'd0 &&
                            abytes_ff == 8'h00 && !phase_ff) begin
                            abytes_ff <= 8'h01;
                            state_ff  <= nxt_wr ? ST_WRITE_ENABLE_CMD : ST_MAIN;
                            sh_ff     <= nxt_wr ? {`SPC_OP_WRITE_ENABLE_CMD, 96'h0}
                                                : sh_ff;
                            nbits_ff  <= 8'd8;
                            rbits_ff  <= 7'd0;
                            // Reads keep select high; their frame loads next.
                            cs_n_ff   <= !nxt_wr;
                            mosi_ff   <= 1'b0;
                        end else begin
                            state_ff <= ST_DONE;
                        end
                    end else if (polls_ff == POLL_MAX[15:0]) begin
                        err_ff   <= 1'b1;
                        state_ff <= ST_DONE;
                    end else begin
                        polls_ff <= polls_ff + 16'h0001;
                        sh_ff    <= {`SPC_OP_RDSR, 96'h0};
                        nbits_ff <= 8'd8;
                        rbits_ff <= 7'd8;
                        cs_n_ff  <= 1'b0;
                        mosi_ff  <= 1'b0;
                    end
                end else if (state_ff == ST_WRITE_ENABLE_CMD) begin
                    state_ff <= ST_MAIN;
                    abytes_ff <= 8'h01;
                end else begin
                    if (abytes_ff == 8'h01) begin
                        // Load the main frame: op, address, write data.
                        wdat_ff <= spc_lsb_first({whi_ff, wlo_ff});
                        sh_ff   <= (nxt_amode == 2'd2 ||
                                    (nxt_amode == 2'd1 && wide_ff)) ?
                                   {op_ff, addr_ff,
                                    spc_lsb_first({whi_ff, wlo_ff})} :
                                   (nxt_amode == 2'd1) ?
                                   {op_ff, addr_ff[23:0],
                                    spc_lsb_first({whi_ff, wlo_ff}), 8'h00} :
                                   {op_ff, spc_lsb_first({whi_ff, wlo_ff}),
                                    32'h00000000};
                        nbits_ff <= 8'd8 + ((nxt_amode == 2'd2 ||
                                    (nxt_amode == 2'd1 && wide_ff)) ? 8'd32 :
                                    (nxt_amode == 2'd1) ? 8'd24 : 8'd0) +
                                    {1'b0, nxt_wbits};
                        rbits_ff  <= nxt_rbits;
                        abytes_ff <= 8'h02;
                        cs_n_ff   <= 1'b0;
                        mosi_ff   <= op_ff[7];
                    end else begin
                        // Older bits from earlier frames are shifted away.
                        rdata_ff <= spc_lsb_first(rsh_ff <<
                                    (7'd64 - rbits_ff));
                        state_ff <= nxt_wr ? ST_GAP : ST_DONE;
                        op_ff    <= nxt_wr ? 8'h00 : op_ff;
                        abytes_ff <= 8'h00;
                    end
                end
            end
            if (state_ff == ST_DONE) begin
                busy_ff  <= 1'b0;
                state_ff <= ST_IDLE;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/spc_flash_model.sv ====
// Behavioural serial flash that answers the protection commands.
`timescale 1ns/1ns
`default_nettype none
module spc_flash_model #(
    parameter logic [15:0] CFG_INIT = 16'hA5F6,
    parameter logic [63:0] KEY_INIT = 64'h0123456789ABCDEF
) (
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic ext,
    output var  logic miso
);
    int          busy_ns = 1500;
    int          n = 0;
    logic [7:0]  op = 8'h00;
    logic [63:0] sh = 64'h0;
    logic [63:0] tx = 64'h0;
    logic        act = 1'b0;
    logic        write_enable_latch = 1'b0;
    logic        write_in_progress = 1'b0;
    logic [15:0] cfg = CFG_INIT;
    logic [63:0] key = KEY_INIT;
    logic [7:0]  lock = 8'h01;
    logic        persistent_prot_bit [0:255];
    wire  [5:0]  alen = (op == 8'hE2 || op == 8'hE3 ||
        (ext && (op == 8'hFC || op == 8'hFD))) ? 6'd32 : 6'd24;
    function automatic logic [63:0] brev(input logic [63:0] v);
        for (int i = 0; i < 8; i++) brev[63-8*i -: 8] = v[8*i +: 8];
    endfunction
    // Values are replicated so that rotating gives the repeat pattern.
    task automatic load(input logic [63:0] v);
        tx = brev(v);
        act = 1'b1;
    endtask
    // Completion of a self-timed write drops both status bits.
    task automatic busy();
        write_in_progress = 1'b1;
        #(busy_ns);
        write_in_progress = 1'b0;
        write_enable_latch = 1'b0;
    endtask
    initial begin
        miso = 1'b0;
        for (int i = 0; i < 256; i++) persistent_prot_bit[i] = 1'b1;
    end
    always @(negedge cs_n) begin
        n = 0;
        act = 1'b0;
    end
    always @(posedge sck) if (!cs_n) begin
        sh = {sh[62:0], mosi};
        n = n + 1;
        if (n == 8) begin
            op = sh[7:0];
            case (op)
                8'h05: load({32{write_enable_latch, write_in_progress}});
                8'h2B: load({4{cfg}});
                8'hA7: if (!write_in_progress) load({8{lock}});
                8'hE7: if (cfg[2]) load(key);
                default: ;
            endcase
        end
        if ((op == 8'hFC || op == 8'hE2) && n == 8 + alen)
            load({64{persistent_prot_bit[sh[23:16]]}});
    end
    // A line that nobody drives shows a changing pattern, not old data.
    always @(negedge sck) if (!cs_n) begin
        if (act) begin
            miso = tx[63];
            tx = {tx[62:0], tx[63]};
        end else
            miso = ~miso;
    end
    always @(posedge cs_n) begin
        miso = ~miso;
        if (n == 8 && op == 8'h06)
            write_enable_latch = 1'b1;
        else if (write_enable_latch && !write_in_progress) begin
            case (op)
                8'hFD, 8'hE3: if (n == 8 + alen) begin
                    persistent_prot_bit[sh[23:16]] = 1'b0;
                    busy();
                end
                8'hE4: if (n == 8) begin
                    for (int i = 0; i < 256; i++) persistent_prot_bit[i] = 1'b1;
                    busy();
                end
                8'h2F: if (n == 24) begin
                    cfg = {sh[7:0], sh[15:8]};
                    busy();
                end
                8'hA6: if (n == 8) begin
                    lock[0] = 1'b0;
                    busy();
                end
                8'h91: if (n == 8) begin
                    lock[7] = 1'b1;
                    busy();
                end
                8'hE8: if (n == 72 && cfg[2]) begin
                    key = brev(sh);
                    busy();
                end
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== test/spc_host_properties.sv ====
// Checker on the serial pins of the protection command host.
`timescale 1ns/1ns
`default_nettype none
`include "spc_map.vh"
module spc_host_properties #(
    parameter SCK_HALF = 10,
    parameter POLL_MAX = 65535
) (
    input wire        clk_sys,
    input wire        arst_n,
    input wire [3:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata_ff,
    input wire        cs_n_ff,
    input wire        sck_ff,
    input wire        mosi_ff,
    input wire        miso
);
    logic       sck_d_ff, wide_ff, first_ff;
    logic [7:0] sh_ff, op_ff, prev_ff, bits_ff, hi_ff;
    wire        rise = sck_ff & ~sck_d_ff;
    wire        go = reg_wr && reg_addr == `SPC_REG_CTRL &&
                     reg_wdata[`SPC_CTRL_GO];
    wire  [7:0] alen = (op_ff == 8'hE2 || op_ff == 8'hE3 || (wide_ff &&
                (op_ff == 8'hFC || op_ff == 8'hFD))) ? 8'd32 : 8'd24;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {sck_d_ff, wide_ff, first_ff} <= 3'h0;
            {sh_ff, op_ff, prev_ff, bits_ff, hi_ff} <= 40'h0;
        end else begin
            sck_d_ff <= sck_ff;
            hi_ff <= sck_ff ? hi_ff + 8'h01 : 8'h00;
            if (go) begin
                wide_ff <= reg_wdata[`SPC_CTRL_WIDE];
                first_ff <= 1'b1;
            end else if (bits_ff == 8'h08)
                first_ff <= 1'b0;
            if (cs_n_ff)
                bits_ff <= 8'h00;
            else if (rise) begin
                bits_ff <= bits_ff + 8'h01;
                sh_ff <= {sh_ff[6:0], mosi_ff};
                if (bits_ff == 8'h07) begin
                    op_ff <= {sh_ff[6:0], mosi_ff};
                    prev_ff <= op_ff;
                end
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_end;
        $rose(cs_n_ff);
    endsequence
    property p_sck_idle; cs_n_ff |-> !sck_ff; endproperty
    property p_mosi_hold; $rose(sck_ff) |-> $stable(mosi_ff); endproperty
    property p_half; $fell(sck_ff) |-> hi_ff == SCK_HALF; endproperty
    property p_byte_edge; s_end |-> bits_ff[2:0] == 3'h0; endproperty
    property p_write_enable_cmd_first;
        bits_ff == 8'h08 && op_ff inside {8'hFD, 8'hE3, 8'hE4, 8'h2F,
            8'hA6, 8'h91, 8'hE8} |-> prev_ff == 8'h06;
    endproperty
    property p_poll_first;
        first_ff && bits_ff == 8'h08 |-> op_ff == 8'h05;
    endproperty
    property p_len_cfg; s_end ##0 op_ff == 8'h2F |-> bits_ff == 8'd24;
    endproperty
    property p_len_key; s_end ##0 op_ff == 8'hE8 |-> bits_ff == 8'd72;
    endproperty
    property p_len_instr;
        s_end ##0 op_ff inside {8'hE4, 8'hA6, 8'h91} |-> bits_ff == 8'd8;
    endproperty
    property p_len_addr;
        s_end ##0 op_ff inside {8'hFD, 8'hE3} |-> bits_ff == alen + 8'd8;
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("serial clock high while deselected");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("data out moved on a rising serial clock");
    a_half: assert property (p_half)
        else $error("serial clock half period wrong");
    a_byte_edge: assert property (p_byte_edge)
        else $error("frame ended off a byte boundary");
    a_write_enable_cmd_first: assert property (p_write_enable_cmd_first)
        else $error("write command without write enable frame");
    a_poll_first: assert property (p_poll_first)
        else $error("command not preceded by a status poll");
    a_len_cfg: assert property (p_len_cfg)
        else $error("configuration program frame length wrong");
    a_len_key: assert property (p_len_key)
        else $error("key program frame length wrong");
    a_len_instr: assert property (p_len_instr)
        else $error("instruction only frame length wrong");
    a_len_addr: assert property (p_len_addr)
        else $error("protection program frame length wrong");
endmodule
bind spc_host spc_host_properties #(.SCK_HALF(SCK_HALF),
    .POLL_MAX(POLL_MAX)) u_props (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .cs_n_ff(cs_n_ff),
    .sck_ff(sck_ff), .mosi_ff(mosi_ff), .miso(miso));
`default_nettype wire

// ==== test/spc_host_test.sv ====
// Self-checking bench for the protection command host controller.
`timescale 1ns/1ns
`default_nettype none
`include "spc_map.vh"
module spc_host_test;
    localparam logic [63:0] B1 = 64'hFF;
    localparam logic [63:0] B2 = 64'hFFFF;
    localparam logic [63:0] B8 = '1;
    localparam logic [63:0] KEY = 64'h1122334455667788;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        ext_flag = 1'b0;
    logic [31:0] s;
    logic [63:0] r;
    wire  [31:0] reg_rdata_ff;
    wire         cs_n_ff, sck_ff, mosi_ff, miso;
    int          fails = 0;
    int          tests_run = 0;
    spc_host #(.SCK_HALF(4), .POLL_MAX(4)) DUT (.clk_sys(clk_sys),
        .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .cs_n_ff(cs_n_ff), .sck_ff(sck_ff), .mosi_ff(mosi_ff),
        .miso(miso));
    spc_flash_model FLASH (.cs_n(cs_n_ff), .sck(sck_ff), .mosi(mosi_ff),
        .ext(ext_flag), .miso(miso));
    initial forever #2 clk_sys = ~clk_sys;
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata_ff;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Polling is bounded so a stuck busy flag ends as a mismatch.
    task automatic cmd(input logic [7:0] op, input logic w);
        int i;
        wr(`SPC_REG_CTRL, {22'h0, w, 1'b1, op});
        for (i = 0; i < 4000; i++) begin
            rd(`SPC_REG_STAT, s);
            if (s[`SPC_STAT_BUSY] === 1'b0) break;
        end
        if (i == 4000) chk(64'h0, 64'h1);
    endtask
    task automatic rdop(input logic [7:0] op, input logic w,
                        input logic [63:0] m, input logic [63:0] e);
        cmd(op, w);
        rd(`SPC_REG_RLO, r[31:0]);
        rd(`SPC_REG_RHI, r[63:32]);
        chk(r & m, e);
    endtask
    task automatic wrap_up();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #300000;
        fails++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(`SPC_REG_STAT, s);
        chk({32'h0, s}, 64'h0);
        rd(4'hF, s);
        chk({32'h0, s}, 64'h0);
        rdop(8'h2B, 1'b0, B2, 64'hA5F6);
        rdop(8'hE7, 1'b0, B8, 64'h0123456789ABCDEF);
        wr(`SPC_REG_WLO, KEY[31:0]);
        wr(`SPC_REG_WHI, KEY[63:32]);
        cmd(8'hE8, 1'b0);
        rdop(8'hE7, 1'b0, B8, KEY);
        wr(`SPC_REG_ADDR, 32'h00030000);
        rdop(8'hFC, 1'b0, B1, 64'hFF);
        cmd(8'hFD, 1'b0);
        rdop(8'hFC, 1'b0, B1, 64'h00);
        ext_flag <= 1'b1;
        wr(`SPC_REG_ADDR, 32'h12050000);
        cmd(8'hE3, 1'b0);
        rdop(8'hFC, 1'b1, B1, 64'h00);
        rdop(8'hE2, 1'b0, B1, 64'h00);
        cmd(8'hE4, 1'b0);
        rdop(8'hE2, 1'b0, B1, 64'hFF);
        rdop(8'hA7, 1'b0, B1, 64'h01);
        cmd(8'hA6, 1'b0);
        rdop(8'hA7, 1'b0, B1, 64'h00);
        cmd(8'h91, 1'b0);
        rdop(8'hA7, 1'b0, B1, 64'h80);
        wr(`SPC_REG_WLO, 32'h000033FB);
        cmd(8'h2F, 1'b0);
        rdop(8'h2B, 1'b0, B2, 64'h33FB);
        rdop(8'hE7, 1'b0, 64'h0, 64'h0);
        chk({63'h0, r === KEY}, 64'h0);
        FLASH.busy_ns = 100000;
        cmd(8'hE4, 1'b0);
        chk({63'h0, s[`SPC_STAT_ERR]}, 64'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
